// ==== rtl/ha_cfg.svh ====
// constants for the 8-bit harvard core: widths, addresses, flags
// assumes nothing; included by bare name
`ifndef HA_CFG_SVH
`define HA_CFG_SVH
// instruction word width
`define HA_IR_W 12
// data word width
`define HA_DW 8
// default program counter width (1k words)
`define HA_PW 10
// direct file address width
`define HA_FA_W 5
// no-operation word, also the instruction register reset value
`define HA_NOP 12'h000
// data addresses held inside the core
`define HA_A_INDF 5'h00
`define HA_A_PC 5'h02
`define HA_A_STAT 5'h03
`define HA_A_FSR 5'h04
// status bit positions
`define HA_ST_C 0
`define HA_ST_DIGIT_CARRY 1
`define HA_ST_Z 2
// reset values
`define HA_STAT_RST 8'h00
`define HA_W_RST 8'h00
`define HA_FSR_RST 8'h00
`endif

// ==== rtl/ha_pkg.sv ====
// types shared by the core and its arithmetic unit
// assumes nothing; uses no constants from ha_cfg.svh
package ha_pkg;
	// arithmetic unit operations
	typedef enum logic [3:0] {
		HA_AU_PASS_A,
		HA_AU_PASS_W,
		HA_AU_ZERO,
		HA_AU_ADD,
		HA_AU_SUB,
		HA_AU_INC,
		HA_AU_DEC,
		HA_AU_OR,
		HA_AU_AND,
		HA_AU_XOR,
		HA_AU_COM,
		HA_AU_RR,
		HA_AU_RL,
		HA_AU_SWAP,
		HA_AU_BCLR,
		HA_AU_BSET
	} ha_au_op_type;
endpackage

// ==== rtl/ha_arith.sv ====
// 8-bit arithmetic unit: combinational result and flags
// assumes the caller picks operands and decides which flags to keep
`timescale 1ns/1ps
`include "ha_cfg.svh"
module ha_arith (
	input wire logic [`HA_DW-1:0] a,
	input wire logic [`HA_DW-1:0] w,
	input wire ha_pkg::ha_au_op_type op,
	input wire logic cin,
	input wire logic [2:0] bsel,
	output logic [`HA_DW-1:0] res,
	output logic c,
	output logic digit_carry_flag,
	output logic z
);
	import ha_pkg::*;

	logic [`HA_DW:0] sum; // nine bits, top is carry out of bit 7
	logic [4:0] nib; // five bits, top is carry out of bit 3
	logic [`HA_DW-1:0] bmask; // one-hot bit select

	////////////////////////////////////////////////////////////////////////
	// operation select
	always_comb begin
		bmask = 8'h01 << bsel;
		sum = 9'h000;
		nib = 5'h00;
		res = a;
		c = cin;
		digit_carry_flag = 1'b0;
		case (op)
			HA_AU_PASS_A: res = a;
			HA_AU_PASS_W: res = w;
			HA_AU_ZERO: res = 8'h00;
			HA_AU_ADD: begin // two's complement add [RQ10] [RQ17]
				sum = {1'b0, a} + {1'b0, w};
				nib = {1'b0, a[3:0]} + {1'b0, w[3:0]};
				res = sum[7:0];
				c = sum[8];
				digit_carry_flag = nib[4];
			end
			HA_AU_SUB: begin // file minus w; carry high means no borrow [RQ15]
				sum = {1'b0, a} + {1'b0, ~w} + 9'h001;
				nib = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
				res = sum[7:0];
				c = sum[8];
				digit_carry_flag = nib[4];
			end
			HA_AU_INC: res = a + 8'h01;
			HA_AU_DEC: res = a - 8'h01;
			HA_AU_OR: res = a | w; // logical group [RQ9]
			HA_AU_AND: res = a & w;
			HA_AU_XOR: res = a ^ w;
			HA_AU_COM: res = ~a;
			HA_AU_RR: begin // shift right through carry [RQ9]
				res = {cin, a[7:1]};
				c = a[0];
			end
			HA_AU_RL: begin // shift left through carry
				res = {a[6:0], cin};
				c = a[7];
			end
			HA_AU_SWAP: res = {a[3:0], a[7:4]};
			HA_AU_BCLR: res = a & ~bmask;
			HA_AU_BSET: res = a | bmask;
			default: res = a;
		endcase
	end

	// zero flag from the full 8-bit result [RQ16]
	assign z = (res == 8'h00);
endmodule // ha_arith

// ==== rtl/ha_core.sv ====
// execution core of an 8-bit harvard controller with a 12-bit word
// assumes program and data memories answer in the cycle the address stands
`timescale 1ns/1ps
`include "ha_cfg.svh"
// Notes on behaviour
// [RQ1] one 12-bit word fetched per cycle
// [RQ2] separate program and data buses
// [RQ3] fetch of next overlaps current execute
// [RQ4] one cycle per instruction except branches
// [RQ5] taken branch kills fetched word, two cycles
// [RQ6] program width set to 512, 1k, 2k
// [RQ7] pc and status sit in data space
// [RQ8] direct and indirect file addressing, orthogonal
// [RQ9] 8-bit add, subtract, shift, logic
// [RQ10] arithmetic is two's complement
// [RQ11] two operands: w and file or literal
// [RQ12] one operand: w or a file
// [RQ13] w is 8 bits, no data address
// [RQ14] carry, digit carry, zero updated per instruction
// [RQ15] subtract: carries act as borrows
// [RQ16] zero flag set when result is zero
// [RQ17] digit carry from nibble, carry from bit 7
module ha_core #(
	parameter int PW = `HA_PW // 9, 10 or 11 bits of program address [RQ6]
) (
	input wire logic clock,
	input wire logic nrst,
	output logic [PW-1:0] prog_addr_r,
	input wire logic [`HA_IR_W-1:0] prog_data,
	output logic [`HA_FA_W-1:0] data_raddr_r,
	output logic data_re_r,
	input wire logic [`HA_DW-1:0] data_rdata,
	output logic data_we_r,
	output logic [`HA_FA_W-1:0] data_waddr_r,
	output logic [`HA_DW-1:0] data_wdata_r,
	output logic [`HA_DW-1:0] w_r,
	output logic [`HA_DW-1:0] stat_r
);
	import ha_pkg::*;

	logic [`HA_IR_W-1:0] ir_r; // instruction in execute
	logic kill_r; // word in ir_r was fetched behind a branch
	logic [`HA_DW-1:0] fsr_r; // indirect pointer
	logic [`HA_DW-1:0] ext_val; // external read with write forwarding
	logic [`HA_DW-1:0] file_val; // operand read from the file space
	logic [`HA_DW-1:0] au_a; // first operand of the arithmetic unit
	logic [`HA_DW-1:0] au_res;
	logic au_c;
	logic au_digit_carry;
	logic au_z;
	ha_au_op_type op;
	logic use_lit; // literal instead of file operand
	logic wr_w;
	logic wr_f;
	logic fz;
	logic fdc;
	logic fc;
	logic skz; // skip when result is zero
	logic bsk; // bit test skip
	logic is_goto;
	logic skip;
	logic pc_wr;
	logic branch;
	logic [PW-1:0] target;
	logic [`HA_DW-1:0] stat_nxt;
	logic [`HA_DW-1:0] fsr_nxt;
	logic [`HA_FA_W-1:0] eff_addr; // address of the word being fetched
	logic eff_int; // that address lands on a core register

	// true when an address is held inside the core
	function automatic logic is_int(input logic [`HA_FA_W-1:0] a);
		is_int = (a == `HA_A_INDF) || (a == `HA_A_PC) ||
			(a == `HA_A_STAT) || (a == `HA_A_FSR);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// operand read
	// a write still pending on the bus is forwarded, since the memory
	// sees it in the same cycle as the next read
	always_comb begin
		ext_val = data_rdata;
		if (data_we_r && (data_waddr_r == data_raddr_r)) begin
			ext_val = data_wdata_r;
		end
		case (data_raddr_r) // core registers mapped in data space [RQ7]
			`HA_A_INDF: file_val = 8'h00; // pointer aimed at itself
			`HA_A_PC: file_val = prog_addr_r[7:0];
			`HA_A_STAT: file_val = stat_r;
			`HA_A_FSR: file_val = fsr_r;
			default: file_val = ext_val;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// decode of the word in execute
	always_comb begin
		op = HA_AU_PASS_A;
		use_lit = 1'b0;
		wr_w = 1'b0;
		wr_f = 1'b0;
		fz = 1'b0;
		fdc = 1'b0;
		fc = 1'b0;
		skz = 1'b0;
		bsk = 1'b0;
		is_goto = 1'b0;
		if (!kill_r) begin // killed word acts as a no-op [RQ5]
			case (ir_r[11:10])
				2'b00: begin // file ops, result to w or file [RQ11] [RQ12]
					wr_w = !ir_r[5];
					wr_f = ir_r[5];
					case (ir_r[9:6])
						4'h0: begin // store w, or no-op when d is clear
							op = HA_AU_PASS_W;
							wr_w = 1'b0;
						end
						4'h1: begin
							op = HA_AU_ZERO;
							fz = 1'b1;
						end
						4'h2: begin // flags per instruction [RQ14]
							op = HA_AU_SUB;
							{fz, fdc, fc} = 3'b111;
						end
						4'h3: begin
							op = HA_AU_DEC;
							fz = 1'b1;
						end
						4'h4: begin
							op = HA_AU_OR;
							fz = 1'b1;
						end
						4'h5: begin
							op = HA_AU_AND;
							fz = 1'b1;
						end
						4'h6: begin
							op = HA_AU_XOR;
							fz = 1'b1;
						end
						4'h7: begin
							op = HA_AU_ADD;
							{fz, fdc, fc} = 3'b111;
						end
						4'h8: fz = 1'b1;
						4'h9: begin
							op = HA_AU_COM;
							fz = 1'b1;
						end
						4'ha: begin
							op = HA_AU_INC;
							fz = 1'b1;
						end
						4'hb: begin
							op = HA_AU_DEC;
							skz = 1'b1;
						end
						4'hc: begin
							op = HA_AU_RR;
							fc = 1'b1;
						end
						4'hd: begin
							op = HA_AU_RL;
							fc = 1'b1;
						end
						4'he: op = HA_AU_SWAP;
						default: begin
							op = HA_AU_INC;
							skz = 1'b1;
						end
					endcase
				end
				2'b01: begin // bit set, clear and test on any file
					if (ir_r[9]) begin
						bsk = 1'b1;
					end else begin
						op = ir_r[8] ? HA_AU_BSET : HA_AU_BCLR;
						wr_f = 1'b1;
					end
				end
				2'b10: begin // literal ops into w [RQ11]
					use_lit = 1'b1;
					wr_w = 1'b1;
					case (ir_r[9:8])
						2'b00: op = HA_AU_PASS_A;
						2'b01: op = HA_AU_OR;
						2'b10: op = HA_AU_AND;
						default: op = HA_AU_XOR;
					endcase
					fz = (ir_r[9:8] != 2'b00);
				end
				default: is_goto = 1'b1;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// arithmetic unit on w and file or literal [RQ9] [RQ13]
	assign au_a = use_lit ? ir_r[7:0] : file_val;

	ha_arith u_arith (
		.a(au_a),
		.w(w_r),
		.op(op),
		.cin(stat_r[`HA_ST_C]),
		.bsel(ir_r[7:5]),
		.res(au_res),
		.c(au_c),
		.digit_carry_flag(au_digit_carry),
		.z(au_z)
	);

	////////////////////////////////////////////////////////////////////////
	// flow change: goto, skips and writes to the pc location
	always_comb begin
		skip = (skz && au_z) || (bsk && (file_val[ir_r[7:5]] == ir_r[8]));
		pc_wr = wr_f && (data_raddr_r == `HA_A_PC);
		branch = is_goto || skip || pc_wr; // [RQ4] [RQ5]
		target = prog_addr_r + {{(PW-1){1'b0}}, 1'b1};
		if (is_goto) begin
			target = PW'(ir_r[9:0]);
		end else if (pc_wr) begin
			target[7:0] = au_res;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next status and pointer; flag updates win over a plain write
	always_comb begin
		stat_nxt = stat_r;
		if (wr_f && (data_raddr_r == `HA_A_STAT)) begin
			stat_nxt = au_res;
		end
		if (fc) begin
			stat_nxt[`HA_ST_C] = au_c; // [RQ14] [RQ17]
		end
		if (fdc) begin
			stat_nxt[`HA_ST_DIGIT_CARRY] = au_digit_carry;
		end
		if (fz) begin
			stat_nxt[`HA_ST_Z] = au_z; // [RQ16]
		end
		fsr_nxt = fsr_r;
		if (wr_f && (data_raddr_r == `HA_A_FSR)) begin
			fsr_nxt = au_res;
		end
	end

	// fetch side address; pointer forwarded so back-to-back indirect works
	always_comb begin
		eff_addr = prog_data[4:0];
		if (eff_addr == `HA_A_INDF) begin
			eff_addr = fsr_nxt[4:0]; // indirect through the pointer [RQ8]
		end
		eff_int = is_int(eff_addr);
	end

	////////////////////////////////////////////////////////////////////////
	// fetch stage: next word captured while this one executes [RQ1] [RQ3]
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			prog_addr_r <= '1;
			ir_r <= `HA_NOP;
			kill_r <= 1'b0;
		end else begin
			ir_r <= prog_data;
			kill_r <= branch; // [RQ5]
			prog_addr_r <= target;
		end
	end

	// data read address runs beside the fetch [RQ2]
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			data_raddr_r <= 5'h00;
			data_re_r <= 1'b0;
		end else begin
			data_raddr_r <= eff_addr;
			data_re_r <= !branch && !eff_int && !prog_data[11];
		end
	end

	// external write of a file result
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			data_we_r <= 1'b0;
			data_waddr_r <= 5'h00;
			data_wdata_r <= 8'h00;
		end else begin
			data_we_r <= wr_f && !is_int(data_raddr_r);
			data_waddr_r <= data_raddr_r;
			data_wdata_r <= au_res;
		end
	end

	// working register, never decoded as a data address [RQ13]
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			w_r <= `HA_W_RST;
		end else if (wr_w) begin
			w_r <= au_res;
		end
	end

	// status and pointer registers
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			stat_r <= `HA_STAT_RST;
			fsr_r <= `HA_FSR_RST;
		end else begin
			stat_r <= stat_nxt;
			fsr_r <= fsr_nxt;
		end
	end
endmodule // ha_core

// ==== tb/ha_mem.sv ====
// program rom and data ram beside the core
// assumes the bench loads rom and ram by hierarchy
`timescale 1ns/1ps
`include "ha_cfg.svh"
module ha_mem #(
	parameter int PW = 10
) (
	input wire logic clock,
	input wire logic [PW-1:0] prog_addr,
	output logic [`HA_IR_W-1:0] prog_data,
	input wire logic [`HA_FA_W-1:0] data_raddr,
	input wire logic data_re,
	output logic [`HA_DW-1:0] data_rdata,
	input wire logic data_we,
	input wire logic [`HA_FA_W-1:0] data_waddr,
	input wire logic [`HA_DW-1:0] data_wdata
);
	logic [`HA_IR_W-1:0] rom [2**PW]; // whole word per address
	logic [`HA_DW-1:0] ram [32]; // file registers
	assign prog_data = rom[prog_addr];
	// unselected reads show junk so a stray sample is caught
	assign data_rdata = data_re ? ram[data_raddr] : ~ram[data_raddr];
	// write at the end of the strobe cycle
	always @(posedge clock) begin
		if (data_we) begin
			ram[data_waddr] <= data_wdata;
		end
	end
endmodule // ha_mem

// ==== tb/ha_core_chk.sv ====
// timing checker for the core ports
// assumes bind onto ha_core
`timescale 1ns/1ps
`include "ha_cfg.svh"
module ha_core_chk #(
	parameter int PW = 10
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [PW-1:0] prog_addr_r,
	input wire logic [`HA_IR_W-1:0] prog_data,
	input wire logic [`HA_FA_W-1:0] data_raddr_r,
	input wire logic data_re_r,
	input wire logic [`HA_DW-1:0] data_rdata,
	input wire logic data_we_r,
	input wire logic [`HA_FA_W-1:0] data_waddr_r,
	input wire logic [`HA_DW-1:0] data_wdata_r,
	input wire logic [`HA_DW-1:0] w_r,
	input wire logic [`HA_DW-1:0] stat_r
);
	logic [11:0] ir_q; // word in execute
	logic [PW-1:0] pa_q; // its fetch address
	logic dead; // fetch did not step, so the word behind a jump is killed
	logic skp_q; // previous word was a bit test or a decrement skip; whether it skipped is not modelled
	logic live; // high unless the fetch jumped or the last live word was a bit test or decrement skip
	logic [8:0] sum9; // carry and sum of w plus file
	// a taken skip steps the fetch as usual, so the address alone cannot
	// tell its killed word apart; words behind a bit test or decrement skip are left unchecked
	assign dead = prog_addr_r != pa_q + 1'b1;
	assign live = !dead && !skp_q;
	assign sum9 = {1'b0, w_r} + {1'b0, data_rdata};
	// shadow the fetch stage
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ir_q <= `HA_NOP;
			pa_q <= '1;
			skp_q <= 1'b0;
		end else begin
			ir_q <= prog_data;
			pa_q <= prog_addr_r;
			skp_q <= live && (ir_q[11:9] == 3'b011 || (ir_q[11:9] == 3'b001 && ir_q[8:6] == 3'b011));
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	sequence s_goto; live && ir_q[11:10] == 2'b11; endsequence
	// forwarding would hide data_rdata, so only with no write pending
	sequence s_add; live && ir_q[11:5] == 7'h0e && ir_q[4:0] > 5'h04 && !data_we_r; endsequence
	sequence s_lit_log; live && ir_q[11:10] == 2'b10 && ir_q[9:8] != 2'b00; endsequence
	property p_lit_step; ir_q[11:10] == 2'b10 |=> prog_addr_r == $past(prog_addr_r) + 1'b1;
	endproperty
	property p_goto; s_goto |=> (prog_addr_r == PW'($past(ir_q[9:0])) && dead) ##1 live;
	endproperty
	property p_kill_re; dead |-> !data_re_r; endproperty
	property p_kill_we; dead |=> !data_we_r; endproperty
	property p_lit_mov; live && ir_q[11:8] == 4'h8 |=> w_r == $past(ir_q[7:0]) && $stable(stat_r);
	endproperty
	property p_lit_z; s_lit_log |=> stat_r[2] == (w_r == 8'h00) && $stable(stat_r[1:0]);
	endproperty
	property p_add; s_add |=> {stat_r[0], w_r} == $past(sum9); endproperty
	property p_bit_rd; live && ir_q[11:10] == 2'b01 && ir_q[4:0] > 5'h04
		|-> data_re_r && data_raddr_r == ir_q[4:0]; endproperty
	a_lit_step: assert property (p_lit_step) else $error("fetch did not step");
	a_goto: assert property (p_goto) else $error("branch timing wrong");
	a_kill_re: assert property (p_kill_re) else $error("killed word read");
	a_kill_we: assert property (p_kill_we) else $error("killed word wrote");
	a_lit_mov: assert property (p_lit_mov) else $error("literal move wrong");
	a_lit_z: assert property (p_lit_z) else $error("zero flag wrong");
	a_add: assert property (p_add) else $error("add result wrong");
	a_bit_rd: assert property (p_bit_rd) else $error("file read wrong");
endmodule // ha_core_chk

// ==== tb/ha_core_tb.sv ====
// self-checking bench for the core
// assumes ha_mem as program and data memory
`timescale 1ns/1ps
`include "ha_cfg.svh"
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
	$display("CHECK FAILED t=%0t %s", $time, m); end end
module ha_core_tb;
	localparam int PW = 10;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic [PW-1:0] prog_addr_r;
	logic [11:0] prog_data;
	logic [4:0] data_raddr_r, data_waddr_r;
	logic data_re_r, data_we_r;
	logic [7:0] data_rdata, data_wdata_r, w_r, stat_r;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #2.5 clock = ~clock;
	ha_core #(.PW(PW)) i_ha_core (.clock(clock), .nrst(nrst), .prog_addr_r(prog_addr_r),
		.prog_data(prog_data), .data_raddr_r(data_raddr_r), .data_re_r(data_re_r),
		.data_rdata(data_rdata), .data_we_r(data_we_r), .data_waddr_r(data_waddr_r),
		.data_wdata_r(data_wdata_r), .w_r(w_r), .stat_r(stat_r));
	ha_mem #(.PW(PW)) i_ha_mem (.clock(clock), .prog_addr(prog_addr_r), .prog_data(prog_data),
		.data_raddr(data_raddr_r), .data_re(data_re_r), .data_rdata(data_rdata),
		.data_we(data_we_r), .data_waddr(data_waddr_r), .data_wdata(data_wdata_r));
	// verdict and end of run
	task automatic summarize;
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// load a program at 0 under reset, then let it run out into no-ops
	task automatic run(input logic [11:0] p [8]);
		@(negedge clock);
		nrst = 1'b0;
		for (int i = 0; i < 2**PW; i++) i_ha_mem.rom[i] = `HA_NOP;
		for (int i = 0; i < 32; i++) i_ha_mem.ram[i] = 8'h00;
		for (int i = 0; i < 8; i++) i_ha_mem.rom[i] = p[i];
		repeat (2) @(negedge clock);
		nrst = 1'b1;
		repeat (16) @(negedge clock);
	endtask
	// nibble carry out of an add, a store and a bit set
	task automatic t_add;
		run('{12'h80f, 12'h025, 12'h801, 12'h000, 12'h1c5, 12'h566, 12'h000, 12'h000});
		`CHK(w_r, 8'h10, "add sum")
		`CHK(stat_r, 8'h02, "add flags")
		`CHK(i_ha_mem.ram[5], 8'h0f, "store")
		`CHK(i_ha_mem.ram[6], 8'h08, "bit set")
		$display("test add done");
	endtask
	// wrap to zero sets every flag
	task automatic t_zero;
		run('{12'h8ff, 12'h025, 12'h801, 12'h000, 12'h1c5, 12'h000, 12'h000, 12'h000});
		`CHK(w_r, 8'h00, "wrap sum")
		`CHK(stat_r, 8'h07, "wrap flags")
		$display("test zero done");
	endtask
	// borrow shows as carry clear
	task automatic t_sub;
		run('{12'h810, 12'h025, 12'h820, 12'h000, 12'h085, 12'h000, 12'h000, 12'h000});
		`CHK(w_r, 8'hf0, "difference")
		`CHK(stat_r, 8'h02, "borrow flags")
		$display("test sub done");
	endtask
	// word behind a jump must not store
	task automatic t_goto;
		run('{12'h855, 12'hc06, 12'h027, 12'h000, 12'h000, 12'h000, 12'ha0f, 12'h000});
		`CHK(w_r, 8'h05, "target ran")
		`CHK(i_ha_mem.ram[7], 8'h00, "killed store")
		`CHK(stat_r, 8'h00, "and flags")
		$display("test goto done");
	endtask
	// pointer set through its data address, then indirect store and read back
	task automatic t_ind;
		run('{12'h809, 12'h024, 12'h8a5, 12'h020, 12'h1c0, 12'h026, 12'h202, 12'h000});
		`CHK(i_ha_mem.ram[9], 8'ha5, "indirect store")
		`CHK(i_ha_mem.ram[6], 8'h4a, "indirect add")
		`CHK(w_r, 8'h07, "pc read as file")
		`CHK(stat_r, 8'h01, "carry kept")
		$display("test ind done");
	endtask
	// a taken skip kills one word, a missed one kills none
	task automatic t_skip;
		run('{12'h801, 12'h025, 12'h2e5, 12'h026, 12'h2e5, 12'h027, 12'h000, 12'h000});
		`CHK(i_ha_mem.ram[5], 8'hff, "decrement twice")
		`CHK(i_ha_mem.ram[6], 8'h00, "skipped store")
		`CHK(i_ha_mem.ram[7], 8'h01, "store after no skip")
		$display("test skip done");
	endtask
	// hang guard, far above the 122 cycles the tests need
	always @(posedge clock) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			summarize();
		end
	end
	initial begin
		// no-ops everywhere, so the cycle before the first load fetches no unknowns
		for (int i = 0; i < 2**PW; i++) i_ha_mem.rom[i] = `HA_NOP;
		repeat (8) @(negedge clock);
		nrst = 1'b1;
		t_add();
		t_zero();
		t_sub();
		t_goto();
		t_ind();
		t_skip();
		summarize();
	end
endmodule // ha_core_tb
bind ha_core ha_core_chk #(.PW(PW)) i_ha_core_chk (.clock(clock), .nrst(nrst),
	.prog_addr_r(prog_addr_r), .prog_data(prog_data), .data_raddr_r(data_raddr_r),
	.data_re_r(data_re_r), .data_rdata(data_rdata), .data_we_r(data_we_r),
	.data_waddr_r(data_waddr_r), .data_wdata_r(data_wdata_r), .w_r(w_r), .stat_r(stat_r));
